// File: verilog/srr_defs.svh
// timing and layout constants for the serial result readout host
`ifndef SRR_DEFS_SVH
`define SRR_DEFS_SVH
`define SRR_RESULT_BITS      18
`define SRR_BYTES_PER_READ   3
`define SRR_BITS_PER_BYTE    8
`define SRR_SYS_CLK_MHZ      125
`define SRR_SCLK_MAX_MBPS    17
`define SRR_SCLK_HALF_CYC    ((`SRR_SYS_CLK_MHZ + 2 * `SRR_SCLK_MAX_MBPS - 1) / (2 * `SRR_SCLK_MAX_MBPS))
`define SRR_CNV_LOW_NS       24
`define SRR_CNV_LOW_CYC      ((`SRR_CNV_LOW_NS * `SRR_SYS_CLK_MHZ + 999) / 1000)
`endif

// File: verilog/srr_pkg.sv
// types for the serial result readout host
package srr_pkg;
    typedef enum logic [4:0] {
        SRR_IDLE  = 5'b0_0001,
        SRR_START = 5'b0_0010,
        SRR_WAIT  = 5'b0_0100,
        SRR_SHIFT = 5'b0_1000,
        SRR_DONE  = 5'b1_0000
    } srr_state_t;
    typedef struct packed {
        logic select_n;
        logic read_n;
        logic sclk;
        logic conversion_start_n;
    } srr_pins_t;
endpackage

// File: verilog/srr_host.sv
// host controller reading 18-bit results over the slave serial port
//
// Behaviour
// - result readable after busy falls while select and read strobe stay low
// - read-after-conversion shift clock may run up to 40 mhz
// - host drives one shared conversion start to every chained device
// - during conversion the previous result is shifted out
// - host does not ensure all 18 bits finish before the running conversion ends; overrun reports a late read
// - no cascading during conversion; chain input tied to a fixed level; host still shifts 18 bits per chained device when reading during conversion
// - host starts a gated shift clock right after the convert strobe, not limited to the first half of conversion
// - read may finish after the next conversion has started
// - spi host reads each result as one unbroken burst of 18 clock pulses per chained device
// - spi master mode, clock polarity 0, clock phase 1
// - host serial clock limited to 17 mbps
// - host starts each read when busy falls, or right after the convert strobe when reading during conversion
`include "srr_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module srr_host #(
    parameter int CHAIN_LEN = 1,
    parameter int HALF_CYC  = `SRR_SCLK_HALF_CYC
) (
    input  wire logic                              sys_clk,
    input  wire logic                              rst,
    input  wire logic                              clk_en,
    input  wire logic                              start,
    input  wire logic                              read_during_conv,
    input  wire logic                              busy,
    input  wire logic                              serial_data_out,
    input  wire logic                              read_overrun_flag,
    output logic                                   conversion_start_n,
    output logic                                   select_n,
    output logic                                   read_n,
    output logic                                   sclk,
    output logic                                   iface_sel0,
    output logic                                   iface_sel1,
    output logic                                   clock_source_select,
    output logic                                   chain_input,
    output logic [`SRR_RESULT_BITS*CHAIN_LEN-1:0]  result,
    output logic                                   result_valid,
    output logic                                   overrun,
    output logic                                   ready
);
    localparam int NBITS = `SRR_RESULT_BITS * CHAIN_LEN;
    localparam int CW    = $clog2(NBITS + 1);
    localparam int HW    = $clog2(HALF_CYC + `SRR_CNV_LOW_CYC + 1);

    localparam int NSYNC = 3;
    localparam int SYNC_DELAY = 2;

    // the data pin is read two cycles late, so a half period at or below that would catch a stale bit
    initial begin
        if (CHAIN_LEN < 1) begin
            $error("srr_host: chain length must be at least one");
        end
        if (HALF_CYC <= SYNC_DELAY) begin
            $error("srr_host: half period must exceed the synchroniser delay");
        end
        if (HW < 1 || CW < 1) begin
            $error("srr_host: counter width collapsed");
        end
    end

    function automatic logic srr_is(input srr_pkg::srr_state_t cur,
                                    input srr_pkg::srr_state_t want);
        return cur == want;
    endfunction

    // pin inputs pass two flops before use
    wire  [NSYNC-1:0] pin_in;
    logic [NSYNC-1:0] pin_meta_r;
    logic [NSYNC-1:0] pin_sync_r;
    logic             busy_d_r;

    assign pin_in = {read_overrun_flag, serial_data_out, busy};

    srr_pkg::srr_state_t state_r;
    srr_pkg::srr_state_t state_nxt;
    srr_pkg::srr_pins_t  pins_r;
    srr_pkg::srr_pins_t  pins_nxt;

    logic [HW-1:0]    tmr_r;
    logic [CW-1:0]    bit_cnt_r;
    logic [NBITS-1:0] shreg_r;
    logic             rdc_mode_r;

    wire busy_q     = pin_sync_r[0];
    wire sdo_q      = pin_sync_r[1];
    wire ovr_q      = pin_sync_r[2];
    wire in_idle    = srr_is(state_r, srr_pkg::SRR_IDLE);
    wire in_start   = srr_is(state_r, srr_pkg::SRR_START);
    wire in_wait    = srr_is(state_r, srr_pkg::SRR_WAIT);
    wire in_done    = srr_is(state_r, srr_pkg::SRR_DONE);
    wire going_idle = srr_is(state_nxt, srr_pkg::SRR_IDLE);
    wire busy_fall  = busy_d_r & ~busy_q;
    wire tmr_done   = (tmr_r == '0);
    wire last_bit   = (bit_cnt_r == CW'(NBITS - 1));
    wire in_shift   = srr_is(state_r, srr_pkg::SRR_SHIFT);
    wire rise_now   = in_shift & tmr_done & ~pins_r.sclk;
    wire fall_now   = in_shift & tmr_done & pins_r.sclk;
    // host may not launch a read while the last one still shifts
    wire can_start  = in_idle;
    wire take_start = can_start & start;

    always_comb begin
        state_nxt = state_r;
        pins_nxt  = pins_r;
        case (state_r)
            srr_pkg::SRR_IDLE: begin
                if (start) begin
                    pins_nxt.conversion_start_n = 1'b0;
                    state_nxt = srr_pkg::SRR_START;
                end
            end
            srr_pkg::SRR_START: begin
                if (tmr_done) begin
                    pins_nxt.conversion_start_n = 1'b1;
                    if (rdc_mode_r) begin
                        // previous result read while converting; gated fast clock
                        pins_nxt.select_n = 1'b0;
                        pins_nxt.read_n   = 1'b0;
                        state_nxt = srr_pkg::SRR_SHIFT;
                    end else begin
                        state_nxt = srr_pkg::SRR_WAIT;
                    end
                end
            end
            srr_pkg::SRR_WAIT: begin
                if (busy_fall) begin
                    pins_nxt.select_n = 1'b0;
                    pins_nxt.read_n   = 1'b0;
                    state_nxt = srr_pkg::SRR_SHIFT;
                end
            end
            srr_pkg::SRR_SHIFT: begin
                if (rise_now) begin
                    pins_nxt.sclk = 1'b1;
                end else if (fall_now) begin
                    pins_nxt.sclk = 1'b0;
                    if (last_bit) begin
                        state_nxt = srr_pkg::SRR_DONE;
                    end
                end
            end
            srr_pkg::SRR_DONE: begin
                pins_nxt.select_n = 1'b1;
                pins_nxt.read_n   = 1'b1;
                state_nxt = srr_pkg::SRR_IDLE;
            end
            default: begin
                state_nxt = srr_pkg::SRR_IDLE;
                pins_nxt  = '{1'b1, 1'b1, 1'b0, 1'b1};
            end
        endcase
    end

    // only the second flop of each pair is read by logic
    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            always_ff @(posedge sys_clk or posedge rst) begin
                if (rst) begin
                    pin_meta_r[gi] <= 1'b0;
                    pin_sync_r[gi] <= 1'b0;
                end else if (clk_en) begin
                    pin_meta_r[gi] <= pin_in[gi];
                    pin_sync_r[gi] <= pin_meta_r[gi];
                end
            end
        end
    endgenerate

    // busy edge detector starts low, matching the idle level of the pin
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            busy_d_r <= 1'b0;
        end else if (clk_en) begin
            busy_d_r <= busy_q;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_r    <= srr_pkg::SRR_IDLE;
            pins_r     <= '{1'b1, 1'b1, 1'b0, 1'b1};
            rdc_mode_r <= 1'b0;
        end else if (clk_en) begin
            state_r <= state_nxt;
            pins_r  <= pins_nxt;
            if (take_start) begin
                rdc_mode_r <= read_during_conv;
            end
        end
    end

    // half-period timer: sclk half period rounds up, so rate never exceeds the limit
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            tmr_r <= '0;
        end else if (clk_en) begin
            if (take_start) begin
                tmr_r <= HW'(`SRR_CNV_LOW_CYC - 1);
            end else if (in_wait || (in_start && tmr_done)) begin
                tmr_r <= HW'(HALF_CYC - 1);
            end else if (in_shift) begin
                tmr_r <= tmr_done ? HW'(HALF_CYC - 1) : tmr_r - HW'(1);
            end else if (!tmr_done) begin
                tmr_r <= tmr_r - HW'(1);
            end
        end
    end

    // sample on the falling edge (cpha 1): device shifts on rising, holds through fall.
    // sync delay is two cycles, kept below the half period so the bit is still stable.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            bit_cnt_r <= '0;
            shreg_r   <= '0;
        end else if (clk_en) begin
            if (in_wait || in_start) begin
                bit_cnt_r <= '0;
            end else if (fall_now) begin
                shreg_r   <= {shreg_r[NBITS-2:0], sdo_q};
                bit_cnt_r <= bit_cnt_r + CW'(1);
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            result       <= '0;
            result_valid <= 1'b0;
            overrun      <= 1'b0;
            ready        <= 1'b1;
        end else if (clk_en) begin
            result_valid <= in_done;
            if (in_done) begin
                result <= shreg_r;
            end
            // level mirror only: a pulse shorter than one cycle would be lost
            overrun <= ovr_q;
            ready   <= going_idle;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            conversion_start_n  <= 1'b1;
            select_n            <= 1'b1;
            read_n              <= 1'b1;
            sclk                <= 1'b0;
            iface_sel0          <= 1'b1;
            iface_sel1          <= 1'b1;
            clock_source_select <= 1'b1;
            chain_input         <= 1'b0;
        end else if (clk_en) begin
            conversion_start_n  <= pins_nxt.conversion_start_n;
            select_n            <= pins_nxt.select_n;
            read_n              <= pins_nxt.read_n;
            sclk                <= pins_nxt.sclk;
            iface_sel0          <= 1'b1;
            iface_sel1          <= 1'b1;
            clock_source_select <= 1'b1;
            chain_input         <= 1'b0;
        end
    end
endmodule // srr_host
`default_nettype wire

// File: dv/srr_host_sva.sv
// port assertions for the serial result readout host
`include "srr_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module srr_host_sva #(parameter int CHAIN_LEN = 1, parameter int HALF_CYC = 4) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic conversion_start_n,
    input wire logic select_n,
    input wire logic read_n,
    input wire logic sclk,
    input wire logic iface_sel0,
    input wire logic iface_sel1,
    input wire logic clock_source_select,
    input wire logic chain_input,
    input wire logic read_overrun_flag,
    input wire logic overrun,
    input wire logic result_valid
);
    int hi_r;
    int nf_r;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // counters instead of long repetitions keep the tools fast
    always_ff @(posedge sys_clk or posedge rst)
        if (rst) hi_r <= 0; else hi_r <= sclk ? hi_r + 1 : 0;
    always_ff @(posedge sys_clk or posedge rst)
        if (rst) nf_r <= 0; else nf_r <= select_n ? 0 : nf_r + int'($fell(sclk));
    property p_cnv; $fell(conversion_start_n) |-> !conversion_start_n [*3] ##1 conversion_start_n; endproperty
    a_cnv: assert property (p_cnv) else $error("convert strobe width wrong");
    property p_pair; select_n == read_n; endproperty
    a_pair: assert property (p_pair) else $error("strobes differ");
    property p_idle; select_n |-> !sclk; endproperty
    a_idle: assert property (p_idle) else $error("clock not idle low");
    property p_fix; iface_sel0 && iface_sel1 && clock_source_select && !chain_input; endproperty
    a_fix: assert property (p_fix) else $error("mode pins wrong");
    property p_half; $fell(sclk) |-> hi_r == HALF_CYC; endproperty
    a_half: assert property (p_half) else $error("clock high time wrong");
    property p_bits; $rose(select_n) |-> nf_r == `SRR_RESULT_BITS * CHAIN_LEN; endproperty
    a_bits: assert property (p_bits) else $error("bit count wrong");
    property p_valid; $rose(select_n) |-> result_valid ##1 !result_valid; endproperty
    a_valid: assert property (p_valid) else $error("valid pulse wrong");
    property p_ovr; $rose(read_overrun_flag) |-> ##[2:4] overrun; endproperty
    a_ovr: assert property (p_ovr) else $error("overrun not passed on");
    c_read: cover property ($rose(result_valid));
    c_ovr: cover property ($rose(overrun));
    c_cnv: cover property ($fell(conversion_start_n));
endmodule // srr_host_sva
bind srr_host srr_host_sva #(.CHAIN_LEN(CHAIN_LEN), .HALF_CYC(HALF_CYC)) i_sva (.*);
`default_nettype wire

// File: dv/srr_adc_model.sv
// behavioural converter with the slave serial readout port
`timescale 1ns/1ns
`default_nettype none
module srr_adc_model (
    input  wire logic        conversion_start_n,
    input  wire logic        select_n,
    input  wire logic        read_n,
    input  wire logic        sclk,
    input  wire logic        chain_input,
    input  wire logic        iface_sel0,
    input  wire logic        iface_sel1,
    input  wire logic        clock_source_select,
    input  wire logic [15:0] conv_ns,
    input  wire logic [17:0] next_val,
    output logic             busy = 1'b0,
    output logic             serial_data_out,
    output logic             read_overrun_flag = 1'b0
);
    logic [17:0] res = 18'h0_0000;
    logic [17:0] sr  = 18'h0_0000;
    logic        cb  = 1'b0;
    logic        dur = 1'b0;
    int          nb  = 0;
    wire         en  = !select_n && !read_n && iface_sel0 && iface_sel1 && clock_source_select;
    // a conversion cannot be restarted while busy
    always @(negedge conversion_start_n) if (!busy) begin
        busy = 1'b1;
        #(conv_ns) res = next_val;
        busy = 1'b0;
        if (dur && nb < 18) begin
            read_overrun_flag = 1'b1;
            #40 read_overrun_flag = 1'b0;
        end
        dur = 1'b0;
    end
    always @(negedge select_n) begin sr = res; nb = 0; dur = busy; end
    always @(negedge sclk) if (!select_n) cb = chain_input;
    always @(posedge sclk) if (!select_n) begin
        if (nb > 0) sr = {sr[16:0], cb};
        nb++;
    end
    // released line shows the inverse so a stale bit never reads as good
    assign serial_data_out = en ? sr[17] : ~sr[17];
endmodule // srr_adc_model
`default_nettype wire

// File: dv/srr_host_bench.sv
// self-checking bench for the serial result readout host
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
    $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module srr_host_bench;
    logic        sys_clk = 1'b0, rst = 1'b1, clk_en = 1'b1, start = 1'b0, read_during_conv = 1'b0, seen = 1'b0;
    logic [15:0] conv_ns  = 16'h0640;
    logic [17:0] next_val = 18'h0_0000, prev = 18'h0_0000, exp_v;
    logic [17:0] q[$];
    logic [31:0] seed     = 32'h4da8_a016;
    int          num_errors = 0, n_checks = 0;
    wire         busy, serial_data_out, read_overrun_flag, conversion_start_n, select_n, read_n, sclk;
    wire         iface_sel0, iface_sel1, clock_source_select, chain_input, result_valid, overrun, ready;
    wire  [17:0] result;
    srr_host i_dut (.*);
    srr_adc_model i_adc (.*);
    initial forever #4 sys_clk = ~sys_clk;
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task automatic final_report();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // scoreboard: oldest note against each delivered result
    // falling edge: outputs launched on the rising edge are settled by then
    always @(negedge sys_clk) begin
        if (overrun === 1'b1) seen = 1'b1;
        if (result_valid === 1'b1) begin
            exp_v = q.size() > 0 ? q.pop_front() : ~result;
            `CHK(result, exp_v)
        end
    end
    // one conversion and read; during-conversion reads return the older value
    task automatic run(input logic m, input logic [15:0] cns, input logic ovr);
        int k;
        seed = xs(seed);
        next_val = seed[17:0];
        conv_ns = cns;
        q.push_back(m ? prev : next_val);
        prev = next_val;
        seen = 1'b0;
        read_during_conv = m;
        start = 1'b1;
        @(posedge sys_clk);
        #1 start = 1'b0;
        // next start only once the converter is idle again
        for (k = 0; k < 2000 && !(ready === 1'b1 && q.size() == 0 && busy === 1'b0); k++) begin
            @(posedge sys_clk);
            #1;
        end
        if (k == 2000) begin
            num_errors++;
            return;
        end
        repeat (25) @(posedge sys_clk);
        #1 `CHK(seen, ovr)
    endtask
    initial begin
        repeat (10) @(posedge sys_clk);
        #1 rst = 1'b0;
        for (int i = 0; i < 6; i++) run(i[0], 16'h0640, 1'b0);
        run(1'b1, 16'h0190, 1'b1);
        run(1'b0, 16'h0190, 1'b0);
        final_report();
    end
endmodule // srr_host_bench
`default_nettype wire
